// ### design/rwpm_map.vh
// constants for the rom window page mapper
// assumes a 16-bit cpu address bus and a 17-bit flat flash address
`ifndef RWPM_MAP_VH
`define RWPM_MAP_VH
`define RWPM_SEL_ADDR 16'hfff3
`define RWPM_SEL_RESET 8'h00
`define RWPM_PAGE_LSB 0
`define RWPM_PAGE_W 3
`define RWPM_WIN_BASE 16'h8000
`define RWPM_WIN_LAST 16'hbfff
`define RWPM_COMMON_LAST 16'h7fff
`define RWPM_FLASH_WIN_BASE 17'h08000
`define RWPM_PAGE_SPAN_LOG2 14
`define RWPM_PAGES_SMALL 3'h4
`define RWPM_PAGES_LARGE 3'h6
`endif

// ### design/rwpm_translate.v
// address translation from cpu address and page to flat flash address
// assumes the page number has been checked by the caller
`timescale 1ns/10ps
`include "rwpm_map.vh"
module rwpm_translate (
   input wire [15:0] cpu_addr,
   input wire [2:0] page,
   output reg [16:0] flash_addr,
   output reg in_window,
   output reg in_common
);
   always @* begin
      in_common = (cpu_addr <= `RWPM_COMMON_LAST);
      in_window = (cpu_addr >= `RWPM_WIN_BASE) && (cpu_addr <= `RWPM_WIN_LAST);
      if (in_window) begin
         // pages packed back to back above the common area
         flash_addr = `RWPM_FLASH_WIN_BASE + {page, cpu_addr[13:0]};
      end else begin
         flash_addr = {1'b0, cpu_addr};
      end
   end
endmodule // rwpm_translate

// ### design/rwpm_mapper.v
// rom window page mapper: page-select register and flash address steering
// assumes a cpu core issuing one byte access per cycle on sys_clk
// and a flash that takes the registered address one cycle after the access
`timescale 1ns/10ps
`include "rwpm_map.vh"
// Function
// - accesses to 8000h-bfffh go to the page named by the select register.
// - the small variant has pages 0 to 3, the large one pages 0 to 5.
// - 0000h-7fffh always maps to the 32 kb common area beside the one page.
// - page n sits at flat address 08000h plus n times 4000h with no gaps.
// - the select register is a byte at fff3h, read/write, cleared by reset.
// - bits 2:0 hold the page and bits 7:3 read zero; a write of an unimplemented code is ignored.
// - the register is written by an ordinary byte memory write.
module rwpm_mapper #(
   parameter LARGE_VARIANT = 1
) (
   input wire sys_clk,
   input wire srst,
   input wire cpu_req,
   input wire cpu_we,
   input wire [15:0] cpu_addr,
   input wire [7:0] cpu_wdata,
   output reg [7:0] sel_rdata_ff,
   output reg sel_hit_ff,
   output reg flash_req_ff,
   output reg [16:0] flash_addr_ff,
   output reg [2:0] window_page_ff
);
   ////////////////////////////////////////////////////////////////////////
   // local constants

   localparam PAGE_W = `RWPM_PAGE_W;
   localparam PAGE_LSB = `RWPM_PAGE_LSB;
   localparam [7:0] SEL_RESET = `RWPM_SEL_RESET;
   // the small variant refuses codes 4 and 5 as well as 6 and 7
   localparam [2:0] PAGE_LIMIT = LARGE_VARIANT ? `RWPM_PAGES_LARGE : `RWPM_PAGES_SMALL;

   ////////////////////////////////////////////////////////////////////////
   // decode helpers

   // shared by the read and the write path, so both decode one address
   function sel_addr_match(input [15:0] addr);
      sel_addr_match = (addr == `RWPM_SEL_ADDR);
   endfunction

   // codes at or above the page count name flash that is not there
   function page_code_ok(input [2:0] code);
      page_code_ok = (code < PAGE_LIMIT);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register state

   reg [2:0] page_sel_ff;

   ////////////////////////////////////////////////////////////////////////
   // combinational values

   reg [2:0] nxt_page_sel;
   reg [2:0] nxt_window_page;
   reg nxt_sel_hit;
   reg [7:0] nxt_sel_rdata;
   reg nxt_flash_req;
   reg [16:0] nxt_flash_addr;

   wire acc_rd;
   wire acc_wr;
   wire sel_rd;
   wire sel_wr;
   wire [2:0] wr_code;

   wire window_page_bit0;
   wire window_page_bit1;
   wire window_page_bit2;
   wire [2:0] cur_page;
   wire [7:0] rd_byte;

   wire [16:0] xl_addr;
   wire xl_win;
   wire xl_common;

   genvar gi;

   ////////////////////////////////////////////////////////////////////////
   // access qualification

   // one access per cycle: a read and a write never coincide
   assign acc_rd = cpu_req && !cpu_we;
   assign acc_wr = cpu_req && cpu_we;
   assign sel_rd = acc_rd && sel_addr_match(cpu_addr);
   assign sel_wr = acc_wr && sel_addr_match(cpu_addr);
   assign wr_code = cpu_wdata[PAGE_LSB +: PAGE_W];

   ////////////////////////////////////////////////////////////////////////
   // page-select register fields

   assign window_page_bit0 = page_sel_ff[0];
   assign window_page_bit1 = page_sel_ff[1];
   assign window_page_bit2 = page_sel_ff[2];
   assign cur_page = {window_page_bit2, window_page_bit1, window_page_bit0};

   // an unimplemented code is dropped rather than stored, so the window
   // never aliases onto flash that does not exist
   always @* begin
      nxt_page_sel = page_sel_ff;
      if (sel_wr) begin
         if (page_code_ok(wr_code)) begin
            nxt_page_sel = wr_code;
         end
      end
   end

   // the visible page copy is a flop of its own so the port is registered
   always @* begin
      nxt_window_page = nxt_page_sel;
   end

   ////////////////////////////////////////////////////////////////////////
   // address steering

   // translation uses the page held before this cycle's write
   rwpm_translate u_xl (
      .cpu_addr(cpu_addr),
      .page(cur_page),
      .flash_addr(xl_addr),
      .in_window(xl_win),
      .in_common(xl_common)
   );

   // writes never start a flash fetch, nor do accesses above bfffh
   always @* begin
      nxt_flash_req = acc_rd && (xl_win || xl_common);
   end

   always @* begin
      nxt_flash_addr = xl_addr;
   end

   ////////////////////////////////////////////////////////////////////////
   // register readback

   // page field at its own position, every other bit reads zero
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_rd_bit
         if ((gi >= PAGE_LSB) && (gi < PAGE_LSB + PAGE_W)) begin : g_field
            assign rd_byte[gi] = cur_page[gi - PAGE_LSB];
         end else begin : g_zero
            assign rd_byte[gi] = 1'b0;
         end
      end
   endgenerate

   // writes hit as well, so a store to the register is seen as decoded
   always @* begin
      nxt_sel_hit = sel_rd || sel_wr;
   end

   // a read returns the page held before any write of the same cycle
   always @* begin
      nxt_sel_rdata = 8'h00;
      if (sel_rd) begin
         nxt_sel_rdata = rd_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flops; every one is cleared by the synchronous reset

   always @(posedge sys_clk) begin
      if (srst) begin
         page_sel_ff <= SEL_RESET[PAGE_W-1:0];
      end else begin
         page_sel_ff <= nxt_page_sel;
      end
   end

   // reset value matches the register, so software sees page 0 both ways
   always @(posedge sys_clk) begin
      if (srst) begin
         window_page_ff <= SEL_RESET[PAGE_W-1:0];
      end else begin
         window_page_ff <= nxt_window_page;
      end
   end

   always @(posedge sys_clk) begin
      if (srst) begin
         sel_hit_ff <= 1'b0;
      end else begin
         sel_hit_ff <= nxt_sel_hit;
      end
   end

   always @(posedge sys_clk) begin
      if (srst) begin
         sel_rdata_ff <= 8'h00;
      end else begin
         sel_rdata_ff <= nxt_sel_rdata;
      end
   end

   // request and address leave together, one cycle after the access
   always @(posedge sys_clk) begin
      if (srst) begin
         flash_req_ff <= 1'b0;
      end else begin
         flash_req_ff <= nxt_flash_req;
      end
   end

   // the address is registered every cycle; flash_req_ff says when it counts
   always @(posedge sys_clk) begin
      if (srst) begin
         flash_addr_ff <= 17'h00000;
      end else begin
         flash_addr_ff <= nxt_flash_addr;
      end
   end
endmodule // rwpm_mapper

// ### verification/rwpm_mapper_properties.sv
// port checker for the mapper, either variant; sys_clk only
`timescale 1ns/10ps
module rwpm_props #(parameter LARGE_VARIANT = 1)
(input wire sys_clk,input wire srst,input wire cpu_req,input wire cpu_we,
input wire [15:0] cpu_addr,input wire [7:0] cpu_wdata,input wire [7:0] sel_rdata_ff,
input wire sel_hit_ff,input wire flash_req_ff,input wire [16:0] flash_addr_ff,
input wire [2:0] window_page_ff);
default clocking @(posedge sys_clk); endclocking
default disable iff (srst);
localparam [2:0] LIM = LARGE_VARIANT ? 3'h6 : 3'h4; // pages that exist
wire rd = cpu_req && !cpu_we;
wire sw = cpu_req && cpu_we && cpu_addr == 16'hfff3;
property p_win; rd && cpu_addr[15:14] == 2'h2 |=> flash_req_ff &&
flash_addr_ff == 17'h08000 + {$past(window_page_ff), $past(cpu_addr[13:0])}; endproperty
a_win: assert property (p_win) else $error("window address wrong");
property p_com; rd && !cpu_addr[15] |=> flash_req_ff && flash_addr_ff == {2'h0, $past(cpu_addr[14:0])};
endproperty
a_com: assert property (p_com) else $error("common address wrong");
property p_rst; disable iff (1'b0) srst |=> window_page_ff == 3'h0; endproperty
a_rst: assert property (p_rst) else $error("page not cleared");
property p_nowr; cpu_req && cpu_we |=> !flash_req_ff; endproperty
a_nowr: assert property (p_nowr) else $error("write started a fetch");
property p_wr; sw && cpu_wdata[2:0] < LIM |=> window_page_ff == $past(cpu_wdata[2:0]); endproperty
a_wr: assert property (p_wr) else $error("page write lost");
property p_rb; rd && cpu_addr == 16'hfff3 |=> sel_hit_ff && sel_rdata_ff == {5'h0, $past(window_page_ff)};
endproperty
a_rb: assert property (p_rb) else $error("readback wrong");
property p_hold; !sw || cpu_wdata[2:0] >= LIM |=> $stable(window_page_ff); endproperty
a_hold: assert property (p_hold) else $error("page moved");
c_wr: cover property (sw);
c_win: cover property (rd && cpu_addr[15:14] == 2'h2);
c_bad: cover property (sw && cpu_wdata[2:0] >= LIM);
endmodule // rwpm_props
bind rwpm_mapper rwpm_props #(.LARGE_VARIANT(LARGE_VARIANT)) chk_i(.*);

// ### verification/rwpm_cpu_model.sv
// cpu side bus model; one byte access, released a cycle later
`timescale 1ns/10ps
module rwpm_cpu(input wire sys_clk,output reg cpu_req,output reg cpu_we,
output reg [15:0] cpu_addr,output reg [7:0] cpu_wdata);
initial {cpu_req, cpu_we, cpu_addr, cpu_wdata} = 26'h0;
// only common-area code is modelled: select writes never come from window code,
// no access straddles 7fffh, interrupts and cross-page hops stay common
task acc(input w, input [15:0] a, input [7:0] d);
@(negedge sys_clk) {cpu_req, cpu_we, cpu_addr, cpu_wdata} = {1'b1, w, a, d};
@(negedge sys_clk) cpu_req = 1'b0;
endtask
endmodule // rwpm_cpu

// ### verification/test_rwpm_mapper.sv
// mapper bench; checks sampled on the falling edge after each access
`timescale 1ns/10ps
module test_rwpm_mapper;
reg sys_clk = 0, srst = 1;
integer mismatches = 0, check_count = 0, i, ps;
wire q, w, h, f; wire [15:0] a; wire [7:0] d, rd; wire [16:0] fa; wire [2:0] pg;
wire fs; wire [16:0] fas; wire [2:0] pgs;
rwpm_cpu cpu(.sys_clk(sys_clk), .cpu_req(q), .cpu_we(w), .cpu_addr(a), .cpu_wdata(d));
rwpm_mapper dut(.sys_clk(sys_clk), .srst(srst), .cpu_req(q), .cpu_we(w), .cpu_addr(a),
.cpu_wdata(d), .sel_rdata_ff(rd), .sel_hit_ff(h), .flash_req_ff(f), .flash_addr_ff(fa),
.window_page_ff(pg));
rwpm_mapper #(.LARGE_VARIANT(0)) dut_small(.sys_clk(sys_clk), .srst(srst), .cpu_req(q),
.cpu_we(w), .cpu_addr(a), .cpu_wdata(d), .sel_rdata_ff(), .sel_hit_ff(), .flash_req_ff(fs),
.flash_addr_ff(fas), .window_page_ff(pgs));
task chk(input [17:0] got, input [17:0] exp);
check_count = check_count + 1;
if (got !== exp) begin mismatches = mismatches + 1; $display("MISMATCH %0t got %h want %h", $time, got, exp); end
endtask
task t_pages; for (i = 0; i < 6; i = i + 1) begin
ps = (i < 4) ? i : 3;
cpu.acc(1, 16'hfff3, 8'hf8 | i[7:0]); chk(pg, i[17:0]);
chk(pgs, ps[17:0]);
cpu.acc(0, 16'hbfff, 0); chk({f, fa}, {1'b1, 17'h0bfff + 17'h4000 * i[16:0]});
chk({fs, fas}, {1'b1, 17'h0bfff + 17'h4000 * ps[16:0]});
cpu.acc(0, 16'hfff3, 0); chk({h, rd}, 9'h100 | i[8:0]); end
$display("pages done"); endtask
task t_bad; cpu.acc(1, 16'hfff3, 8'h06); chk(pg, 5);
chk(pgs, 3);
cpu.acc(0, 16'h7fff, 0); chk({f, fa}, {1'b1, 17'h07fff});
cpu.acc(1, 16'h8000, 8'h55); chk({f, fs}, 0);
@(negedge sys_clk) srst = 1; @(negedge sys_clk) srst = 0; chk({pg, pgs}, 0);
$display("bad code and reset done"); endtask
task give_verdict; $display("checks %0d mismatches %0d", check_count, mismatches);
if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
else $display("Run complete: FAIL");
$finish; endtask
initial forever #2 sys_clk = ~sys_clk;
initial begin repeat (20) @(negedge sys_clk); srst = 0; t_pages; t_bad; give_verdict; end
endmodule // test_rwpm_mapper
